//--- dv/scs_card_model.sv
// Behavioural character engine and link clock feeding the card block
`timescale 1ns/1ps
`default_nettype none
module scs_card_model (
	input wire logic go_i,
	input wire logic [4:0] ev_i,
	input wire logic [7:0] byte_i,
	output logic link_clk_o,
	output logic [4:0] strb_o,
	output logic [7:0] rx_byte_o
);
	initial begin
		link_clk_o = 0;
		strb_o = 0;
		rx_byte_o = 8'h00;
	end
	// Link clock stands still between characters: one rising edge per frame
	always @(posedge go_i) begin
		rx_byte_o = byte_i;
		// Offset from the clock edge so the synchroniser never races the change
		#330 strb_o = ev_i;
		#160 link_clk_o = 1;
		#160 link_clk_o = 0;
		strb_o = 0;
		// Byte is not held after the frame, so a late sample shows garbage
		#320 rx_byte_o = ~byte_i;
	end
endmodule // scs_card_model
`default_nettype wire

//--- dv/scs_top_chk.sv
// Bus and flag assertions for the card interrupt block
`timescale 1ns/1ps
`default_nettype none
module scs_top_chk (
	input wire logic CLK_I,
	input wire logic RESET_I,
	input wire logic PSEL_I,
	input wire logic PENABLE_I,
	input wire logic PWRITE_I,
	input wire logic [7:0] PADDR_I,
	input wire logic [31:0] PWDATA_I,
	input wire logic [31:0] PRDATA_O,
	input wire logic PREADY_O,
	input wire logic PSLVERR_O,
	input wire logic [7:0] TX_BYTE_O,
	input wire logic TX_FULL_O,
	input wire logic CARD_OP_REQUEST_O,
	input wire logic IRQ_O
);
	default clocking @(posedge CLK_I); endclocking
	default disable iff (RESET_I);
	wire rd_pend = PREADY_O && !PWRITE_I && PADDR_I == 8'h00;
	wire wr_tx = PREADY_O && PWRITE_I && !PSLVERR_O && PADDR_I == 8'h08;
	chk_irq_gated: assert property (IRQ_O |-> CARD_OP_REQUEST_O)
		else $error("irq without request");
	chk_ready_time: assert property ($rose(PENABLE_I) && PSEL_I |=> PREADY_O)
		else $error("ready late");
	chk_ready_one: assert property (PREADY_O |=> !PREADY_O)
		else $error("ready too long");
	chk_err_ready: assert property (PSLVERR_O |-> PREADY_O && PSEL_I && PENABLE_I)
		else $error("error outside access");
	chk_unmapped_err: assert property (PREADY_O && PADDR_I > 8'h14 |-> PSLVERR_O)
		else $error("unmapped not refused");
	// Buffer flop loads at the access edge, the output copy one edge later
	chk_tx_copy: assert property (wr_tx |-> ##2 {24'h0, TX_BYTE_O} == ($past(PWDATA_I, 2) & 32'hff))
		else $error("tx byte not written");
	chk_tx_full: assert property (wr_tx |-> ##2 TX_FULL_O)
		else $error("tx full not set");
	chk_pend_shape: assert property (rd_pend |-> PRDATA_O[31:8] == 0 && !PRDATA_O[6])
		else $error("pending read shape");
	chk_req_read: assert property (rd_pend && PRDATA_O[7:0] != 0 |-> CARD_OP_REQUEST_O)
		else $error("flags without request");
	cover property (rd_pend && PRDATA_O[7:0] != 0);
	cover property ($rose(IRQ_O));
	cover property (PREADY_O && PSLVERR_O);
endmodule // scs_top_chk
bind scs_top scs_top_chk chk_u (.CLK_I(CLK_I), .RESET_I(RESET_I), .PSEL_I(PSEL_I),
	.PENABLE_I(PENABLE_I), .PWRITE_I(PWRITE_I), .PADDR_I(PADDR_I), .PWDATA_I(PWDATA_I),
	.PRDATA_O(PRDATA_O), .PREADY_O(PREADY_O), .PSLVERR_O(PSLVERR_O), .TX_BYTE_O(TX_BYTE_O),
	.TX_FULL_O(TX_FULL_O), .CARD_OP_REQUEST_O(CARD_OP_REQUEST_O), .IRQ_O(IRQ_O));
`default_nettype wire

//--- dv/scs_top_tb_top.sv
// Self-checking bench for the card interrupt block
`timescale 1ns/1ps
`default_nettype none
module scs_top_tb_top;
	logic clk = 0, rst = 1, psel = 0, pen = 0, pwr = 0, go = 0, sup = 0, ovc = 0;
	logic [7:0] padr = 0, byt = 0, txb, rxb;
	logic [31:0] pwd = 0, prd, rd;
	logic prdy, perr, lclk, err, txf, req, irq;
	logic [4:0] stb, ev = 0;
	int mismatches = 0, n_checks = 0;
	initial forever #20 clk = ~clk;
	scs_top dut_u (.CLK_I(clk), .RESET_I(rst), .PSEL_I(psel), .PENABLE_I(pen), .PWRITE_I(pwr),
		.PADDR_I(padr), .PWDATA_I(pwd), .PRDATA_O(prd), .PREADY_O(prdy), .PSLVERR_O(perr),
		.CARD_CLK_I(lclk), .TX_DONE_I(stb[2]), .RX_DONE_I(stb[1]), .PARITY_ERR_I(stb[0]),
		.WAIT_UFLOW_I(stb[3]), .TX_TAKEN_I(stb[4]), .RX_BYTE_I(rxb), .SUPPLY_ERR_I(sup),
		.OVERCURRENT_I(ovc), .TX_BYTE_O(txb), .TX_FULL_O(txf), .CARD_OP_REQUEST_O(req),
		.IRQ_O(irq));
	scs_card_model card_u (.go_i(go), .ev_i(ev), .byte_i(byt), .link_clk_o(lclk),
		.strb_o(stb), .rx_byte_o(rxb));
	task chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("unexpected at %0t: got %h want %h", $time, got, exp);
		end
	endtask
	task cyc(input int n);
		repeat (n) @(posedge clk);
	endtask
	// Idle cycle first so psel is never driven twice in one step
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk);
		psel <= 1;
		pwr <= w;
		padr <= a;
		pwd <= d;
		@(posedge clk);
		pen <= 1;
		do begin
			@(posedge clk);
			n++;
		end while (prdy !== 1'b1);
		chk(prdy, 1);
		chk(n, 2);
		rd = prd;
		err = perr;
		psel <= 0;
		pen <= 0;
	endtask
	task rdc(input logic [7:0] a, input logic [31:0] e);
		apb(0, a, 0);
		chk(rd, e);
	endtask
	// Codes 0..3 and 6 are strobes; 4 and 5 are supply levels
	task fire(input int i, input logic [7:0] b);
		if (i < 4 || i == 6) begin
			ev <= (i == 6) ? 5'h10 : 5'h01 << i;
			byt <= b;
			go <= 1;
			cyc(1);
			go <= 0;
		end else begin
			sup <= (i == 4);
			ovc <= (i == 5);
			cyc(10);
			sup <= 0;
			ovc <= 0;
		end
		cyc(30);
	endtask
	task t_reset;
		chk({txf, req, irq}, 0);
		rdc(8'h00, 0);
		rdc(8'h04, 0);
		rdc(8'h08, 0);
		rdc(8'h0c, 0);
		rdc(8'h14, 32'h2);
		apb(1, 8'h18, 32'hff);
		chk(err, 1);
		rdc(8'h18, 0);
		chk(err, 1);
	endtask
	task t_events;
		apb(1, 8'h08, 32'h3c);
		cyc(2);
		chk({txf, txb}, 9'h13c);
		apb(1, 8'h04, 32'h3f);
		apb(1, 8'h14, 32'h1);
		for (int i = 0; i < 6; i++) begin
			fire(i, 8'ha0 + i[7:0]);
			chk({req, irq}, 2'b11);
			rdc(8'h00, 32'h1 << i);
			cyc(2);
			chk(req, 0);
			if (i == 1) rdc(8'h0c, 32'ha1);
		end
	endtask
	task t_mask;
		apb(1, 8'h04, 32'h1);
		apb(1, 8'h14, 32'h0);
		fire(0, 0);
		chk({req, irq}, 2'b10);
		apb(1, 8'h10, 32'h1);
		cyc(2);
		chk(req, 0);
		apb(1, 8'h04, 0);
		for (int i = 0; i < 6; i++) fire(i, 8'h50 + i[7:0]);
		chk(req, 0);
		rdc(8'h00, 0);
		rdc(8'h0c, 32'h51);
	endtask
	task t_tx;
		apb(1, 8'h04, 32'h80);
		fire(6, 0);
		chk(txf, 0);
		rdc(8'h14, 32'h2);
		rdc(8'h00, 32'h80);
		rdc(8'h00, 32'h80);
		apb(1, 8'h04, 0);
	endtask
	task give_verdict;
		$display("mismatches %0d checks %0d", mismatches, n_checks);
		if (mismatches == 0 && n_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	initial begin
		repeat (20) @(posedge clk);
		rst <= 0;
		t_reset;
		t_events;
		t_mask;
		t_tx;
		give_verdict;
	end
	// About 620 cycles expected; eight times that is a hang
	initial begin
		#200000;
		mismatches++;
		give_verdict;
	end
endmodule // scs_top_tb_top
`default_nettype wire

//--- src/scs_edge.v
// Turns strobes held across a link clock rising edge into one-cycle pulses
`timescale 1ns/1ps
`default_nettype none

module scs_edge #(
	parameter W = 1
) (
	input wire clk_i,
	input wire rst_i,
	input wire link_clk_i,
	input wire [W-1:0] strobe_i,
	output reg [W-1:0] pulse_o
);

	reg link_prev_r;
	wire link_rise;

	assign link_rise = link_clk_i & ~link_prev_r;

	// One pulse per link edge, so a strobe is counted once per link cycle
	genvar g;
	generate
		for (g = 0; g < W; g = g + 1) begin : g_bit
			always @(posedge clk_i or posedge rst_i) begin
				if (rst_i) begin
					pulse_o[g] <= 1'b0;
				end else begin
					pulse_o[g] <= link_rise & strobe_i[g];
				end
			end
		end
	endgenerate

	always @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			link_prev_r <= 1'b0;
		end else begin
			link_prev_r <= link_clk_i;
		end
	end

endmodule // scs_edge

`default_nettype wire

//--- src/scs_map.vh
// Register map, field positions, reset values and timing for the card interrupt block
`ifndef SCS_MAP_VH
`define SCS_MAP_VH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define SCS_OFF_PENDING 8'h00
`define SCS_OFF_ENABLE 8'h04
`define SCS_OFF_TXBUF 8'h08
`define SCS_OFF_RXBUF 8'h0c
`define SCS_OFF_CLEAR 8'h10
`define SCS_OFF_CTRL 8'h14

// ----------------------------------------------------------------
// Pending / enable bit positions
// ----------------------------------------------------------------
`define SCS_BIT_PARITY 0
`define SCS_BIT_RXDONE 1
`define SCS_BIT_TXDONE 2
`define SCS_BIT_WAITUF 3
`define SCS_BIT_SUPPLY 4
`define SCS_BIT_OVERCUR 5
`define SCS_BIT_TXEMPTY 7
`define SCS_IRQ_IMPL_MASK 8'hbf

// ----------------------------------------------------------------
// Control register bits
// ----------------------------------------------------------------
`define SCS_CTRL_OPIRQ 0
`define SCS_CTRL_TXEMPTY 1

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define SCS_RST_BYTE 8'h00
`define SCS_RST_CTRL 1'b0

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define SCS_SYNC_STAGES 2
`define SCS_LINK_PERIOD_NS 320
`define SCS_CLK_PERIOD_NS 40

`endif

//--- src/scs_sync.v
// Two-flop synchroniser for a bundle of asynchronous levels
`timescale 1ns/1ps
`default_nettype none

module scs_sync #(
	parameter W = 1
) (
	input wire clk_i,
	input wire rst_i,
	input wire [W-1:0] async_i,
	output reg [W-1:0] sync_o
);

	reg [W-1:0] meta_r;

	// First stage feeds only the second stage
	always @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			meta_r <= {W{1'b0}};
			sync_o <= {W{1'b0}};
		end else begin
			meta_r <= async_i;
			sync_o <= meta_r;
		end
	end

endmodule // scs_sync

`default_nettype wire

//--- src/scs_top.v
// Smart card interrupt pending flags, enables and character buffers behind APB
//
// How it works
// - Supply error sets its flag when enabled
// - Waiting underflow sets bit 3 when enabled
// - Sent character sets bit 2 when enabled
// - Received character sets bit 1 when enabled
// - Parity fault sets bit 0 when enabled
// - Hardware sets flags; reading pending clears them
// - Software-writable eight-bit transmit byte buffer
// - Each received byte overwrites the receive buffer
// - Empty transmit buffer sets bit 7 when enabled
// - Supply overcurrent sets bit 5 when enabled
// - Cleared enable bit blocks its flag
// - One operation request line toward processor
`include "scs_map.vh"
`timescale 1ns/1ps
`default_nettype none

module scs_top (
	input wire CLK_I,
	input wire RESET_I,
	input wire PSEL_I,
	input wire PENABLE_I,
	input wire PWRITE_I,
	input wire [7:0] PADDR_I,
	input wire [31:0] PWDATA_I,
	output reg [31:0] PRDATA_O,
	output reg PREADY_O,
	output reg PSLVERR_O,
	input wire CARD_CLK_I,
	input wire TX_DONE_I,
	input wire RX_DONE_I,
	input wire PARITY_ERR_I,
	input wire WAIT_UFLOW_I,
	input wire TX_TAKEN_I,
	input wire [7:0] RX_BYTE_I,
	input wire SUPPLY_ERR_I,
	input wire OVERCURRENT_I,
	output reg [7:0] TX_BYTE_O,
	output reg TX_FULL_O,
	output reg CARD_OP_REQUEST_O,
	output reg IRQ_O
);

	// ----------------------------------------------------------------
	// Address decode
	// ----------------------------------------------------------------
	function addr_hit;
		input [7:0] addr;
		input [7:0] off;
		begin
			addr_hit = (addr == off);
		end
	endfunction

	function addr_known;
		input [7:0] addr;
		begin
			addr_known = addr_hit(addr, `SCS_OFF_PENDING) |
				addr_hit(addr, `SCS_OFF_ENABLE) |
				addr_hit(addr, `SCS_OFF_TXBUF) |
				addr_hit(addr, `SCS_OFF_RXBUF) |
				addr_hit(addr, `SCS_OFF_CLEAR) |
				addr_hit(addr, `SCS_OFF_CTRL);
		end
	endfunction

	// ----------------------------------------------------------------
	// Input synchronisation
	// ----------------------------------------------------------------
	wire [15:0] async_bus;
	wire [15:0] sync_bus;
	wire link_clk_s;
	wire supply_err_s;
	wire overcur_s;
	wire [7:0] rx_byte_s;
	wire [4:0] strobe_s;
	wire [4:0] evt_pulse;
	wire tx_done_p;
	wire rx_done_p;
	wire parity_p;
	wire waituf_p;
	wire tx_taken_p;

	assign async_bus = {CARD_CLK_I, TX_DONE_I, RX_DONE_I, PARITY_ERR_I, WAIT_UFLOW_I,
		TX_TAKEN_I, SUPPLY_ERR_I, OVERCURRENT_I, RX_BYTE_I};

	scs_sync #(
		.W(16)
	) u_sync (
		.clk_i(CLK_I),
		.rst_i(RESET_I),
		.async_i(async_bus),
		.sync_o(sync_bus)
	);

	assign link_clk_s = sync_bus[15];
	assign strobe_s = sync_bus[14:10];
	assign supply_err_s = sync_bus[9];
	assign overcur_s = sync_bus[8];
	assign rx_byte_s = sync_bus[7:0];

	// Engine strobes are sampled on the link clock's own rising edge
	scs_edge #(
		.W(5)
	) u_edge (
		.clk_i(CLK_I),
		.rst_i(RESET_I),
		.link_clk_i(link_clk_s),
		.strobe_i(strobe_s),
		.pulse_o(evt_pulse)
	);

	assign tx_done_p = evt_pulse[4];
	assign rx_done_p = evt_pulse[3];
	assign parity_p = evt_pulse[2];
	assign waituf_p = evt_pulse[1];
	assign tx_taken_p = evt_pulse[0];

	// The strobe pulse lags receive data by one cycle after edge detect; align it
	reg [7:0] rx_byte_d_r;

	always @(posedge CLK_I or posedge RESET_I) begin
		if (RESET_I) begin
			rx_byte_d_r <= `SCS_RST_BYTE;
		end else begin
			rx_byte_d_r <= rx_byte_s;
		end
	end

	// ----------------------------------------------------------------
	// APB handshake
	// ----------------------------------------------------------------
	// One wait state lets read data leave straight from a flop
	wire access;
	wire done;
	wire wr_done;
	wire rd_done;

	assign access = PSEL_I & PENABLE_I;
	assign done = access & PREADY_O;
	assign wr_done = done & PWRITE_I & addr_known(PADDR_I);
	assign rd_done = done & ~PWRITE_I & addr_known(PADDR_I);

	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	reg [7:0] card_irq_pending_r;
	reg [7:0] card_irq_pending_nxt;
	reg [7:0] card_irq_enable_r;
	reg [7:0] card_tx_buffer_r;
	reg [7:0] card_rx_buffer_r;
	reg card_op_irq_on_r;
	reg tx_empty_r;
	reg [7:0] read_snap_r;
	reg [7:0] irq_set;
	reg [7:0] irq_clr;
	reg [31:0] rdata_nxt;

	// Flags raise only through their enable bit
	always @* begin
		irq_set = 8'h00;
		irq_set[`SCS_BIT_SUPPLY] = supply_err_s;
		irq_set[`SCS_BIT_WAITUF] = waituf_p;
		irq_set[`SCS_BIT_TXDONE] = tx_done_p;
		irq_set[`SCS_BIT_RXDONE] = rx_done_p;
		irq_set[`SCS_BIT_PARITY] = parity_p;
		irq_set[`SCS_BIT_TXEMPTY] = tx_empty_r;
		irq_set[`SCS_BIT_OVERCUR] = overcur_s;
		irq_set = irq_set & card_irq_enable_r & `SCS_IRQ_IMPL_MASK;
	end

	// A pending read clears only the bits software actually saw, and a same-cycle set wins
	always @* begin
		irq_clr = 8'h00;
		if (rd_done && addr_hit(PADDR_I, `SCS_OFF_PENDING)) begin
			irq_clr = read_snap_r;
		end
		if (wr_done && addr_hit(PADDR_I, `SCS_OFF_CLEAR)) begin
			irq_clr = irq_clr | PWDATA_I[7:0];
		end
		card_irq_pending_nxt = ((card_irq_pending_r & ~irq_clr) | irq_set) &
			`SCS_IRQ_IMPL_MASK;
	end

	always @(posedge CLK_I or posedge RESET_I) begin
		if (RESET_I) begin
			card_irq_pending_r <= 8'h00;
		end else begin
			card_irq_pending_r <= card_irq_pending_nxt;
		end
	end

	always @(posedge CLK_I or posedge RESET_I) begin
		if (RESET_I) begin
			card_irq_enable_r <= 8'h00;
			card_op_irq_on_r <= `SCS_RST_CTRL;
		end else if (wr_done) begin
			if (addr_hit(PADDR_I, `SCS_OFF_ENABLE)) begin
				card_irq_enable_r <= PWDATA_I[7:0] & `SCS_IRQ_IMPL_MASK;
			end
			if (addr_hit(PADDR_I, `SCS_OFF_CTRL)) begin
				card_op_irq_on_r <= PWDATA_I[`SCS_CTRL_OPIRQ];
			end
		end
	end

	// Transmit buffer: a software write fills it, the engine taking it empties it
	always @(posedge CLK_I or posedge RESET_I) begin
		if (RESET_I) begin
			card_tx_buffer_r <= `SCS_RST_BYTE;
			tx_empty_r <= 1'b1;
		end else if (wr_done && addr_hit(PADDR_I, `SCS_OFF_TXBUF)) begin
			card_tx_buffer_r <= PWDATA_I[7:0];
			tx_empty_r <= 1'b0;
		end else if (tx_taken_p) begin
			tx_empty_r <= 1'b1;
		end
	end

	// Hardware load beats a software write; unread data is simply lost
	always @(posedge CLK_I or posedge RESET_I) begin
		if (RESET_I) begin
			card_rx_buffer_r <= `SCS_RST_BYTE;
		end else if (rx_done_p) begin
			card_rx_buffer_r <= rx_byte_d_r;
		end else if (wr_done && addr_hit(PADDR_I, `SCS_OFF_RXBUF)) begin
			card_rx_buffer_r <= PWDATA_I[7:0];
		end
	end

	// ----------------------------------------------------------------
	// Read data and bus answer
	// ----------------------------------------------------------------
	always @* begin
		rdata_nxt = 32'h00000000;
		case (1'b1)
			addr_hit(PADDR_I, `SCS_OFF_PENDING): begin
				rdata_nxt[7:0] = card_irq_pending_r;
			end
			addr_hit(PADDR_I, `SCS_OFF_ENABLE): begin
				rdata_nxt[7:0] = card_irq_enable_r;
			end
			addr_hit(PADDR_I, `SCS_OFF_TXBUF): begin
				rdata_nxt[7:0] = card_tx_buffer_r;
			end
			addr_hit(PADDR_I, `SCS_OFF_RXBUF): begin
				rdata_nxt[7:0] = card_rx_buffer_r;
			end
			addr_hit(PADDR_I, `SCS_OFF_CTRL): begin
				rdata_nxt[`SCS_CTRL_OPIRQ] = card_op_irq_on_r;
				rdata_nxt[`SCS_CTRL_TXEMPTY] = tx_empty_r;
			end
			default: begin
				rdata_nxt = 32'h00000000;
			end
		endcase
	end

	always @(posedge CLK_I or posedge RESET_I) begin
		if (RESET_I) begin
			PRDATA_O <= 32'h00000000;
			PREADY_O <= 1'b0;
			PSLVERR_O <= 1'b0;
			read_snap_r <= 8'h00;
		end else if (access && !PREADY_O) begin
			PREADY_O <= 1'b1;
			PSLVERR_O <= ~addr_known(PADDR_I);
			PRDATA_O <= PWRITE_I ? 32'h00000000 : rdata_nxt;
			read_snap_r <= rdata_nxt[7:0];
		end else begin
			PREADY_O <= 1'b0;
			PSLVERR_O <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// Outputs toward the card engine and the processor
	// ----------------------------------------------------------------
	always @(posedge CLK_I or posedge RESET_I) begin
		if (RESET_I) begin
			TX_BYTE_O <= `SCS_RST_BYTE;
			TX_FULL_O <= 1'b0;
			CARD_OP_REQUEST_O <= 1'b0;
			IRQ_O <= 1'b0;
		end else begin
			TX_BYTE_O <= card_tx_buffer_r;
			TX_FULL_O <= ~tx_empty_r;
			CARD_OP_REQUEST_O <= |card_irq_pending_nxt;
			IRQ_O <= (|card_irq_pending_nxt) & card_op_irq_on_r;
		end
	end

endmodule // scs_top

`default_nettype wire
